// *** shared/bcc_pkg.sv ***
/*
  Package for the boost converter control block: register offset, field
  layout, reset values and timing constants.
  Assumes a 50 MHz system clock; all users reference names as bcc_pkg::name.
*/
package bcc_pkg;
  localparam logic [7:0] VCODE_OFFSET = 8'h0d;
  localparam logic [7:0] VCODE_RESET = 8'h08;
  localparam logic [7:0] VCODE_MIN = 8'h08;
  localparam logic [7:0] VCODE_MAX = 8'h14;
  localparam int CLK_HZ = 50000000;
  localparam int SWITCH_HZ = 1000000;
  localparam int SOFT_START_MS = 20;
  localparam int SOFT_START_CYCLES = (CLK_HZ / 1000) * SOFT_START_MS;
  localparam int MIN_PULSE_NS = 45;
  localparam int CLK_PERIOD_NS = 20;
  // Least time: rounded up to whole cycles
  localparam int MIN_PULSE_CYCLES = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SWITCH_PERIOD_CYCLES = CLK_HZ / SWITCH_HZ;
  // Duty limit as cycles of the switching period
  localparam int MAX_DUTY_CYCLES = 45;
  // Low-current soft-start duty ceiling
  localparam int SOFT_DUTY_CYCLES = 10;
  typedef enum logic [1:0] {BCC_STANDBY, BCC_SOFT_START, BCC_NORMAL} bcc_state_e;
endpackage

// *** shared/bcc_pwm_if.sv ***
/*
  Interface carrying the duty request and switching limits from the
  control sequencer to the pulse generator. Both ends share clk_in.
*/
`timescale 1ns/1ns
interface bcc_pwm_if;
  logic run;
  logic min_pulse_en;
  logic [7:0] duty_req;
  logic [7:0] duty_limit;
  logic sw_on;
  logic cycle_start;
  modport ctrl (output run, output min_pulse_en, output duty_req, output duty_limit,
                input sw_on, input cycle_start);
  modport gen (input run, input min_pulse_en, input duty_req, input duty_limit,
               output sw_on, output cycle_start);
endinterface

// *** verilog/bcc_pwm_gen.sv ***
/*
  Switch pulse generator: at most one pulse per switching period, width clamped
  between the minimum pulse (when enabled) and the duty limit.
  Assumes the period is generated from the internal oscillator tick at clk_in.
*/
`timescale 1ns/1ns
module bcc_pwm_gen #(
  parameter int PERIOD = bcc_pkg::SWITCH_PERIOD_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  bcc_pwm_if.gen pwm
);
  logic [7:0] phase;
  logic [7:0] width;
  logic [7:0] req_lim;
  logic wrap;
  assign wrap = (phase == 8'(PERIOD - 1));
  assign req_lim = (pwm.duty_req > pwm.duty_limit) ? pwm.duty_limit : pwm.duty_req; // [R10]
  // A skipped pulse is prevented only while the active load is on
  assign width = (pwm.min_pulse_en && req_lim < 8'(bcc_pkg::MIN_PULSE_CYCLES)) ?
                 8'(bcc_pkg::MIN_PULSE_CYCLES) : req_lim; // [R9] [R8]

  always_ff @(posedge clk_in) begin
    if (!rstn_in || !pwm.run) begin
      phase <= 8'h00;
      pwm.sw_on <= 1'b0;
      pwm.cycle_start <= 1'b0;
    end else begin
      phase <= wrap ? 8'h00 : phase + 8'h01; // [R11]
      pwm.cycle_start <= wrap;
      pwm.sw_on <= ((wrap ? 8'h00 : phase + 8'h01) < width);
    end
  end

  property p_duty_cap;
    @(posedge clk_in) disable iff (!rstn_in)
    pwm.sw_on |-> (phase < pwm.duty_limit || phase < 8'(bcc_pkg::MIN_PULSE_CYCLES));
  endproperty
  a_duty_cap: assert property (p_duty_cap) // [R10]
    else $error("switch on past duty limit");

  property p_min_pulse_start;
    @(posedge clk_in) disable iff (!rstn_in)
    (pwm.run && $past(pwm.run) && pwm.min_pulse_en && $past(pwm.min_pulse_en) && phase == 8'h00
     && $past(wrap)) |-> pwm.sw_on;
  endproperty
  a_min_pulse_start: assert property (p_min_pulse_start) // [R9]
    else $error("minimum pulse missing");

  property p_min_pulse_hold;
    @(posedge clk_in) disable iff (!rstn_in)
    (pwm.run && pwm.min_pulse_en && phase == 8'h00 && pwm.sw_on) |=> (pwm.sw_on || !pwm.run);
  endproperty
  a_min_pulse_hold: assert property (p_min_pulse_hold) // [R9]
    else $error("minimum pulse too short");

  property p_period_start;
    @(posedge clk_in) disable iff (!rstn_in)
    pwm.cycle_start |-> (phase == 8'h00);
  endproperty
  a_period_start: assert property (p_period_start) // [R11]
    else $error("period start marker out of step");
endmodule

// *** verilog/bcc_top.sv ***
/*
  Boost converter control: run/standby sequencing, soft start, LED
  blanking, output voltage code register with internal clamp, active load.
  Assumes register writes arrive as a synchronous strobe from the serial
  interface logic on clk_in; analog loop sits outside.
*/
//
// Behaviour
// R1: Output voltage is chosen by an 8-bit register with discrete steps.
// R2: Codes 8 to 20 select that many volts, one-volt steps.
// R3: Codes below 8 are used internally as 8.
// R4: Codes above 20 are used internally as 20.
// R5: Clearing run enable stops switching, converter in standby.
// R6: Setting run enable soft-starts 20 ms at low current, then normal.
// R7: All LED outputs forced off during the soft-start interval.
// R8: Clearing active load disconnects discharge; pulses may then be skipped.
// R9: With active load on, every cycle has at least a minimum pulse.
// R10: Switch duty is limited by digital logic.
// R11: Switching is timed from the internal oscillator, 1 MHz nominal.
// R12: Host should disable and set code 8 when no load is attached.
// R13: Run enable already set at startup end goes straight to soft start.
// R14: Register reads back raw value; clamp only feeds the divider.
`timescale 1ns/1ns
module bcc_top #(
  parameter int SOFT_START_CYCLES = bcc_pkg::SOFT_START_CYCLES
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic startup_done_in,
  input wire logic boost_enable_in,
  input wire logic active_load_enable_in,
  input wire logic [7:0] led_request_in,
  input wire logic [7:0] duty_request_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] divider_code_out,
  output logic [7:0] led_enable_out,
  output logic switch_on_out,
  output logic active_load_on_out,
  output logic soft_start_out,
  output logic [1:0] state_out
);
  bcc_pkg::bcc_state_e state;
  bcc_pkg::bcc_state_e next_state;
  logic [7:0] vcode;
  logic [7:0] clamped_code;
  logic [24:0] ss_count;
  logic ss_done;
  logic addr_hit;
  bcc_pwm_if pwm_bus();

  function automatic logic [7:0] clamp_code(input logic [7:0] raw);
    if (raw < bcc_pkg::VCODE_MIN) begin
      return bcc_pkg::VCODE_MIN; // [R3]
    end else if (raw > bcc_pkg::VCODE_MAX) begin
      return bcc_pkg::VCODE_MAX; // [R4]
    end
    return raw; // [R2]
  endfunction

  assign addr_hit = (reg_addr_in == bcc_pkg::VCODE_OFFSET);
  assign clamped_code = clamp_code(vcode); // [R14]
  assign ss_done = (ss_count == 25'(SOFT_START_CYCLES - 1));

  // Full 8-bit storage; any value is accepted and kept as written
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      vcode <= bcc_pkg::VCODE_RESET;
    end else if (reg_write_in && addr_hit) begin
      vcode <= reg_wdata_in; // [R1] [R14]
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      bcc_pkg::BCC_STANDBY: begin
        // Startup gating covers both entry from reset and a later enable
        if (boost_enable_in && startup_done_in) begin
          next_state = bcc_pkg::BCC_SOFT_START; // [R6] [R13]
        end
      end
      bcc_pkg::BCC_SOFT_START: begin
        if (!boost_enable_in || !startup_done_in) begin
          next_state = bcc_pkg::BCC_STANDBY; // [R5]
        end else if (ss_done) begin
          next_state = bcc_pkg::BCC_NORMAL; // [R6]
        end
      end
      bcc_pkg::BCC_NORMAL: begin
        if (!boost_enable_in || !startup_done_in) begin
          next_state = bcc_pkg::BCC_STANDBY; // [R5]
        end
      end
      default: begin
        next_state = bcc_pkg::BCC_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      state <= bcc_pkg::BCC_STANDBY;
      ss_count <= 25'h0000000;
    end else begin
      state <= next_state;
      ss_count <= (state == bcc_pkg::BCC_SOFT_START && !ss_done) ? ss_count + 25'h0000001 : 25'h0000000;
    end
  end

  // Soft start caps duty to keep inrush low
  assign pwm_bus.run = (state != bcc_pkg::BCC_STANDBY); // [R5]
  assign pwm_bus.min_pulse_en = active_load_enable_in; // [R9]
  assign pwm_bus.duty_req = duty_request_in;
  assign pwm_bus.duty_limit = (state == bcc_pkg::BCC_SOFT_START) ?
                              8'(bcc_pkg::SOFT_DUTY_CYCLES) : 8'(bcc_pkg::MAX_DUTY_CYCLES); // [R6] [R10]

  bcc_pwm_gen bcc_pwm_gen_inst (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .pwm(pwm_bus.gen)
  );

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 8'h00;
      divider_code_out <= bcc_pkg::VCODE_RESET;
      led_enable_out <= 8'h00;
      switch_on_out <= 1'b0;
      active_load_on_out <= 1'b0;
      soft_start_out <= 1'b0;
      state_out <= 2'h0;
    end else begin
      reg_rdata_out <= addr_hit ? vcode : 8'h00; // [R14]
      divider_code_out <= clamped_code; // [R2]
      led_enable_out <= (state == bcc_pkg::BCC_SOFT_START) ? 8'h00 : led_request_in; // [R7]
      switch_on_out <= pwm_bus.sw_on;
      // Discharge only meaningful while switching
      active_load_on_out <= active_load_enable_in && (state != bcc_pkg::BCC_STANDBY); // [R8]
      soft_start_out <= (state == bcc_pkg::BCC_SOFT_START);
      state_out <= state;
    end
  end

  property p_clamp_range;
    @(posedge clk_in) disable iff (!rstn_in)
    1'b1 |=> (divider_code_out >= bcc_pkg::VCODE_MIN && divider_code_out <= bcc_pkg::VCODE_MAX);
  endproperty
  a_clamp_range: assert property (p_clamp_range) // [R3] [R4]
    else $error("divider code out of range");

  property p_clamp_high;
    @(posedge clk_in) disable iff (!rstn_in)
    (vcode > bcc_pkg::VCODE_MAX) |=> (divider_code_out == bcc_pkg::VCODE_MAX);
  endproperty
  a_clamp_high: assert property (p_clamp_high) // [R4]
    else $error("high code not clamped");

  property p_clamp_low;
    @(posedge clk_in) disable iff (!rstn_in)
    (vcode < bcc_pkg::VCODE_MIN) |=> (divider_code_out == bcc_pkg::VCODE_MIN);
  endproperty
  a_clamp_low: assert property (p_clamp_low) // [R3]
    else $error("low code not clamped");

  property p_pass_range;
    @(posedge clk_in) disable iff (!rstn_in)
    (vcode >= bcc_pkg::VCODE_MIN && vcode <= bcc_pkg::VCODE_MAX) |=> (divider_code_out == $past(vcode));
  endproperty
  a_pass_range: assert property (p_pass_range) // [R2]
    else $error("in-range code not passed");

  property p_store_raw;
    @(posedge clk_in) disable iff (!rstn_in)
    (reg_write_in && addr_hit) |=> (vcode == $past(reg_wdata_in));
  endproperty
  a_store_raw: assert property (p_store_raw) // [R14]
    else $error("raw value not stored");

  property p_rdata_mapped;
    @(posedge clk_in) disable iff (!rstn_in)
    addr_hit |=> (reg_rdata_out == $past(vcode));
  endproperty
  a_rdata_mapped: assert property (p_rdata_mapped) // [R14]
    else $error("raw value not read back");

  property p_rdata_unmapped;
    @(posedge clk_in) disable iff (!rstn_in)
    !addr_hit |=> (reg_rdata_out == 8'h00);
  endproperty
  a_rdata_unmapped: assert property (p_rdata_unmapped) // [R14]
    else $error("unmapped read not zero");

  // The state follows one edge after the enable drops; the generator one edge later
  property p_standby_stop;
    @(posedge clk_in) disable iff (!rstn_in)
    (!boost_enable_in) |=> (state == bcc_pkg::BCC_STANDBY) ##1 !pwm_bus.sw_on;
  endproperty
  a_standby_stop: assert property (p_standby_stop) // [R5]
    else $error("switching not stopped in standby");

  property p_load_standby;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == bcc_pkg::BCC_STANDBY) |=> !active_load_on_out;
  endproperty
  a_load_standby: assert property (p_load_standby) // [R5] [R8]
    else $error("active load on in standby");

  property p_soft_entry;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == bcc_pkg::BCC_STANDBY && boost_enable_in && startup_done_in) |=>
    (state == bcc_pkg::BCC_SOFT_START);
  endproperty
  a_soft_entry: assert property (p_soft_entry) // [R6] [R13]
    else $error("soft start not entered");

  property p_leds_off;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == bcc_pkg::BCC_SOFT_START) |=> (led_enable_out == 8'h00);
  endproperty
  a_leds_off: assert property (p_leds_off) // [R7]
    else $error("LED on during soft start");

  property p_soft_end;
    @(posedge clk_in) disable iff (!rstn_in)
    (state == bcc_pkg::BCC_SOFT_START && ss_done && boost_enable_in && startup_done_in) |=>
    (state == bcc_pkg::BCC_NORMAL);
  endproperty
  a_soft_end: assert property (p_soft_end) // [R6]
    else $error("soft start did not end");

  property p_ss_bound;
    @(posedge clk_in) disable iff (!rstn_in)
    1'b1 |-> (ss_count < 25'(SOFT_START_CYCLES));
  endproperty
  a_ss_bound: assert property (p_ss_bound) // [R6]
    else $error("soft start counter overran");
endmodule

// *** test/bcc_load_model.sv ***
/*
  Load model for the switch gate: inductor, capacitor and LED strings.
  Assumes the gate is sampled on clk_in; reports width, spacing, count.
*/
`timescale 1ns/1ns
module bcc_load_model (
  input wire logic clk_in,
  input wire logic switch_on_in,
  output int width_out = 0,
  output int spacing_out = 0,
  output int pulses_out = 0
);
  int on_cnt = 0;
  int gap_cnt = 0;
  logic sw_d = 1'b0;
  // Each pulse charges the inductor; width and spacing are measured
  always @(posedge clk_in) begin
    sw_d <= switch_on_in;
    gap_cnt <= gap_cnt + 1;
    if (switch_on_in) on_cnt <= on_cnt + 1;
    if (switch_on_in && !sw_d) begin
      spacing_out <= gap_cnt;
      gap_cnt <= 1;
      pulses_out <= pulses_out + 1;
    end
    if (!switch_on_in && sw_d) begin
      width_out <= on_cnt;
      on_cnt <= 0;
    end
  end
endmodule

// *** test/bcc_tb.sv ***
/*
  Self-checking bench for the boost converter control block.
  Assumes a 50 MHz clock and a shortened soft-start count.
*/
`timescale 1ns/1ns
module boost_converter_control_tb_top;
  localparam int SS = 100;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic startup_done_in = 1'b0;
  logic boost_enable_in = 1'b0;
  logic active_load_enable_in = 1'b0;
  logic [7:0] led_request_in = 8'h00;
  logic [7:0] duty_request_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out, divider_code_out, led_enable_out, d;
  logic switch_on_out, active_load_on_out, soft_start_out;
  logic [1:0] state_out;
  int width, spacing, pulses, p0, seed, k, model;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [7:0] edges[6] = '{8'h00, 8'h07, 8'h08, 8'h14, 8'h15, 8'hff};
  bcc_top #(.SOFT_START_CYCLES(SS)) bcc_top_inst (.clk_in(clk_in), .rstn_in(rstn_in),
    .startup_done_in(startup_done_in), .boost_enable_in(boost_enable_in),
    .active_load_enable_in(active_load_enable_in), .led_request_in(led_request_in),
    .duty_request_in(duty_request_in), .reg_write_in(reg_write_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .divider_code_out(divider_code_out),
    .led_enable_out(led_enable_out), .switch_on_out(switch_on_out),
    .active_load_on_out(active_load_on_out), .soft_start_out(soft_start_out), .state_out(state_out));
  bcc_load_model bcc_load_model_inst (.clk_in(clk_in), .switch_on_in(switch_on_out),
    .width_out(width), .spacing_out(spacing), .pulses_out(pulses));
  always #10 clk_in = ~clk_in;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    reg_write_in = 1'b1;
    reg_addr_in = a;
    reg_wdata_in = v;
    @(negedge clk_in);
    reg_write_in = 1'b0;
    reg_addr_in = bcc_pkg::VCODE_OFFSET;
    cycles(2);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    seed = $urandom(32'h9842a6d5);
    cycles(20);
    rstn_in = 1'b1;
    check("divider reset", divider_code_out, bcc_pkg::VCODE_RESET);
    check("state reset", state_out, 2'd0);
    for (int i = 0; i < 14; i++) begin
      d = (i < 6) ? edges[i] : 8'($urandom_range(0, 255));
      write_reg(bcc_pkg::VCODE_OFFSET, d);
      model = (d < 8) ? 8 : ((d > 20) ? 20 : d);
      check("readback", reg_rdata_out, d);
      check("divider", divider_code_out, 8'(model));
    end
    write_reg(8'h0e, 8'h11);
    check("unmapped write", reg_rdata_out, d);
    reg_addr_in = 8'h0e;
    cycles(1);
    check("unmapped read", reg_rdata_out, 8'h00);
    duty_request_in = 8'd40;
    led_request_in = 8'($urandom);
    boost_enable_in = 1'b1;
    cycles(5);
    check("state before startup", state_out, 2'd0);
    startup_done_in = 1'b1;
    cycles(2);
    check("soft start", soft_start_out, 1'b1);
    check("leds blank", led_enable_out, 8'h00);
    cycles(70);
    check("soft width", width, bcc_pkg::SOFT_DUTY_CYCLES);
    check("leds blank late", led_enable_out, 8'h00);
    for (k = 0; k < 200 && state_out !== 2'd2; k++) cycles(1);
    if (state_out !== 2'd2) begin
      n_mismatch++;
      complete_run();
    end
    cycles(2);
    check("leds normal", led_enable_out, led_request_in);
    cycles(110);
    check("normal width", width, 40);
    check("period", spacing, bcc_pkg::SWITCH_PERIOD_CYCLES);
    duty_request_in = 8'd60;
    cycles(110);
    check("duty limit", width, bcc_pkg::MAX_DUTY_CYCLES);
    duty_request_in = 8'd0;
    active_load_enable_in = 1'b1;
    cycles(110);
    check("min pulse", width, bcc_pkg::MIN_PULSE_CYCLES);
    check("load on", active_load_on_out, 1'b1);
    active_load_enable_in = 1'b0;
    cycles(60);
    p0 = pulses;
    cycles(110);
    check("skip", pulses, p0);
    check("load off", active_load_on_out, 1'b0);
    boost_enable_in = 1'b0;
    cycles(2);
    check("standby", state_out, 2'd0);
    // Duty raised only once standby holds the generator, so no last pulse slips in
    duty_request_in = 8'd40;
    p0 = pulses;
    cycles(110);
    check("no switching", pulses, p0);
    write_reg(bcc_pkg::VCODE_OFFSET, bcc_pkg::VCODE_MIN);
    check("idle code", divider_code_out, bcc_pkg::VCODE_MIN);
    complete_run();
  end
endmodule
